// ===== core/sar_pkg.sv
package sar_pkg;

  localparam int unsigned RES_W       = 12;
  localparam int unsigned CNT_W       = 5;
  localparam int unsigned FRAME_CLKS  = 16;

  localparam logic [CNT_W-1:0] EDGE_SAMPLE    = 5'h02;
  localparam logic [CNT_W-1:0] EDGE_MSB_FIRST = 5'h03;
  localparam logic [CNT_W-1:0] EDGE_MSB_LAST  = 5'h0E;
  localparam logic [CNT_W-1:0] EDGE_LSB_LAST  = 5'h19;
  localparam logic [CNT_W-1:0] EDGE_FRAME_END = 5'h10;
  localparam logic [CNT_W-1:0] EDGE_SAT       = 5'h1F;

  localparam logic             CS_N_RST  = 1'b1;
  localparam logic             SCLK_RST  = 1'b0;
  localparam logic [CNT_W-1:0] CNT_RST   = 5'h00;
  localparam logic [RES_W-1:0] RES_RST   = 12'h000;

  typedef enum logic [2:0] {
    SAR_IDLE  = 3'b000,
    SAR_ACQ   = 3'b001,
    SAR_MSB   = 3'b010,
    SAR_LSB   = 3'b011,
    SAR_TAIL  = 3'b100
  } sar_state_t;

endpackage : sar_pkg

// ===== core/sar_pin_if.sv
interface sar_pin_if;
  logic cs_n_s;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;

  modport src (output cs_n_s, output cs_fall, output cs_rise,
               output sclk_fall);
  modport dst (input cs_n_s, input cs_fall, input cs_rise,
               input sclk_fall);
endinterface : sar_pin_if

// ===== core/sar_pin_sync.sv
module sar_pin_sync
  import sar_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic cs_n,
  input  wire logic sclk,
  sar_pin_if.src    pins
);

  logic [2:0] cs_n_q;
  logic [2:0] sclk_q;

  // Stage 0 feeds stage 1 only; stage 2 is the previous value for edges.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cs_n_q <= {3{CS_N_RST}};
      sclk_q <= {3{SCLK_RST}};
    end else begin
      cs_n_q <= {cs_n_q[1:0], cs_n};
      sclk_q <= {sclk_q[1:0], sclk};
    end
  end

  assign pins.cs_n_s    = cs_n_q[1];
  assign pins.cs_fall   = cs_n_q[2] & ~cs_n_q[1];
  assign pins.cs_rise   = ~cs_n_q[2] & cs_n_q[1];
  assign pins.sclk_fall = sclk_q[2] & ~sclk_q[1];

endmodule : sar_pin_sync

// ===== core/sar_readout.sv
// Behaviour
// - The data output stays released after select falls and is driven only from the second shift clock falling edge on.
// - A select rising edge releases the data output and ends the frame at any bit count.
// - The data output changes only after a shift clock falling edge, one new bit per falling edge.
// - A full frame spans 16 shift clocks, so the top sample rate is the shift clock over 16.
// - The result goes out most significant bit first behind one leading null bit.
// - Further clocking after that word repeats the result least significant bit first.
// - At conversion start the input is sampled and the inputs stay isolated until the conversion ends.
module sar_readout
  import sar_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             cs_n,
  input  wire logic             sclk,
  input  wire logic [RES_W-1:0] conv_result,
  output logic                  sdo_o,
  output logic                  sdo_oe,
  output logic                  sample_pulse,
  output logic                  inputs_isolated,
  output logic                  conv_done,
  output logic                  frame_active
);

  sar_pin_if pins ();

  sar_pin_sync u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .cs_n    (cs_n),
    .sclk    (sclk),
    .pins    (pins)
  );

  sar_state_t       state_q;
  sar_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [RES_W-1:0] res_q;
  logic             sdo_q;
  logic             sdo_oe_q;
  logic             sample_q;
  logic             isolate_q;
  logic             done_q;
  logic             active_q;
  logic             fall_in_frame;

  // Picks the bit presented after falling edge number n of the frame.
  function automatic logic bit_for(input logic [CNT_W-1:0] n,
                                   input logic [RES_W-1:0] r);
    logic b;
    b = 1'b0;
    if (n >= EDGE_MSB_FIRST && n <= EDGE_MSB_LAST) begin
      b = r[4'(EDGE_MSB_LAST - n)];
    end else if (n > EDGE_MSB_LAST && n <= EDGE_LSB_LAST) begin
      b = r[4'(n - EDGE_MSB_LAST)];
    end
    return b;
  endfunction

  assign fall_in_frame = pins.sclk_fall & ~pins.cs_n_s & active_q;
  assign cnt_d = (cnt_q == EDGE_SAT) ? cnt_q : cnt_q + 5'h01;

  always_comb begin
    state_d = state_q;
    case (cnt_d)
      5'h01:          state_d = SAR_ACQ;
      EDGE_SAMPLE:    state_d = SAR_MSB;
      EDGE_MSB_LAST:  state_d = SAR_LSB;
      EDGE_LSB_LAST:  state_d = SAR_TAIL;
      default:        state_d = state_q;
    endcase
  end

  // Frame bookkeeping: opened by select falling, closed by select rising.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= SAR_IDLE;
      cnt_q    <= CNT_RST;
      active_q <= 1'b0;
    end else if (pins.cs_rise) begin
      state_q  <= SAR_IDLE;
      cnt_q    <= CNT_RST;
      active_q <= 1'b0;
    end else if (pins.cs_fall) begin
      state_q  <= SAR_IDLE;
      cnt_q    <= CNT_RST;
      active_q <= 1'b1;
    end else if (fall_in_frame) begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
    end
  end

  // Output driver and data: cleared on select edges, otherwise updated only on falling shift clock edges.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (pins.cs_rise || pins.cs_fall) begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (fall_in_frame) begin
      if (cnt_d == EDGE_SAMPLE) begin
        sdo_oe_q <= 1'b1;
        sdo_q    <= 1'b0;
      end else begin
        sdo_q    <= bit_for(cnt_d, res_q);
      end
    end
  end

  // Sampling, input isolation and result capture.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sample_q  <= 1'b0;
      isolate_q <= 1'b0;
      done_q    <= 1'b0;
      res_q     <= RES_RST;
    end else begin
      sample_q <= 1'b0;
      done_q   <= 1'b0;
      if (pins.cs_rise) begin
        isolate_q <= 1'b0;
      end else if (fall_in_frame) begin
        if (cnt_d == EDGE_SAMPLE) begin
          sample_q  <= 1'b1;
          isolate_q <= 1'b1;
          res_q     <= conv_result;
        end
        if (cnt_d == EDGE_MSB_LAST) begin
          isolate_q <= 1'b0;
          done_q    <= 1'b1;
        end
      end
    end
  end

  assign sdo_o           = sdo_q;
  assign sdo_oe          = sdo_oe_q;
  assign sample_pulse    = sample_q;
  assign inputs_isolated = isolate_q;
  assign conv_done       = done_q;
  assign frame_active    = active_q;

endmodule : sar_readout

// ===== verification/sar_readout_asserts.sv
module sar_readout_asserts (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sample_pulse,
  input wire logic inputs_isolated,
  input wire logic conv_done,
  input wire logic frame_active
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_oe_late: assert property ($rose(sdo_oe) |-> sample_pulse)
    else $error("oe early");
  a_act_rel: assert property ($rose(frame_active) |-> !sdo_oe)
    else $error("oe at start");
  a_oe_frame: assert property (sdo_oe |-> frame_active)
    else $error("oe outside frame");
  a_bit_hold: assert property (sdo_oe && $changed(sdo_o) |->
    $past(sclk, 4) && !$past(sclk, 3)) else $error("bit moved");
  a_null_bit: assert property (sample_pulse |-> sdo_oe && !sdo_o)
    else $error("no null bit");
  a_done_gap: assert property (sample_pulse |=> !conv_done [*8])
    else $error("done early");
  a_iso_start: assert property (sample_pulse |-> inputs_isolated)
    else $error("not isolated");
  a_iso_end: assert property (conv_done |->
    !inputs_isolated && $past(inputs_isolated)) else $error("iso end");
  cover property (conv_done);
  cover property (sample_pulse);
  cover property ($fell(frame_active));
endmodule // sar_readout_asserts
bind sar_readout sar_readout_asserts u_chk (.clk_sys, .arst_n, .sclk,
  .sdo_o, .sdo_oe, .sample_pulse, .inputs_isolated, .conv_done,
  .frame_active);

// ===== verification/sar_host_model.sv
module sar_host_model (
  input  wire logic clk_sys,
  input  wire logic sdo_o,
  input  wire logic sdo_oe,
  output logic      cs_n,
  output logic      sclk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rx = 0;
  logic        got = 0;
  int          early = 0;
  initial begin
    cs_n = 1;
    sclk = 0;
  end
  task automatic frame(input int n, input int h);
    @(negedge clk_sys) cs_n = 0;
    for (int i = 0; i < n; i++) begin
      repeat (h) @(negedge clk_sys);
      sclk = 1;
      // The line must still be released before the second falling edge.
      if (i < 2 && sdo_oe) early++;
      // A released line reads as the inverse of the last bit taken.
      rx = {rx[30:0], sdo_oe ? sdo_o : ~rx[0]};
      repeat (h) @(negedge clk_sys);
      sclk = 0;
    end
    repeat (h) @(negedge clk_sys);
    cs_n = 1;
    got = ~got;
    repeat (h + 4) @(negedge clk_sys);
  endtask
endmodule // sar_host_model

// ===== verification/serial_adc_conversion_readout_tb.sv
module serial_adc_conversion_readout_tb import sar_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic             clk_sys;
  logic             arst_n;
  logic [RES_W-1:0] conv;
  wire              cs_n, sclk, sdo_o, sdo_oe;
  int               n_fail = 0;
  int               checked = 0;
  int               seed = 32'hFEF1A11F;
  int               ns[5] = '{16, 14, 15, 27, 34};
  logic [63:0]      q[$];
  logic [63:0]      w;
  sar_readout dut (.clk_sys, .arst_n, .cs_n, .sclk, .conv_result(conv),
    .sdo_o, .sdo_oe, .sample_pulse(), .inputs_isolated(), .conv_done(),
    .frame_active());
  sar_host_model u_host (.clk_sys, .sdo_o, .sdo_oe, .cs_n, .sclk);
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    n_fail++;
    give_verdict;
  end
  task give_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  function automatic logic [31:0] expw(input int n, input logic [11:0] r);
    logic [31:0] e;
    e = 0;
    for (int k = 2; k < n; k++)
      e = {e[30:0], k == 2 ? 1'b0 : k < 15 ? r[14-k] :
           k < 26 ? r[k-14] : 1'b0};
    return e;
  endfunction
  always @(u_host.got) begin
    w = q.pop_front();
    check(u_host.rx & w[63:32], w[31:0]);
    check(32'(u_host.early), 32'h00000000);
  end
  initial begin
    arst_n = 0;
    conv = 0;
    repeat (5) @(negedge clk_sys);
    arst_n = 1;
    repeat (4) @(negedge clk_sys);
    foreach (ns[i]) begin
      conv = 12'($random(seed));
      q.push_back({32'hFFFFFFFF >> (34 - ns[i]), expw(ns[i], conv)});
      u_host.frame(ns[i], 4 + 2 * (i % 2));
    end
    give_verdict;
  end
endmodule // serial_adc_conversion_readout_tb
